// >>> vbrc_top.sv
// Regulator control and bus power detection with AHB-Lite register slave
// Function
// - Software switches the regulator off or on
// - Low-power select bit puts regulator in suspend mode
// - Read-only status bit shows present bus power level
// - Enabled interrupt raised when level matches polarity
// - Bus power interrupt is level, never latched
// - Interrupt drops once level stops matching, no clear
// - Reset request issued on match when reset source enabled
// - Polarity 0 active low, 1 active high
// - Status reads 1 when bus power present
// - Off bit resets to 0, 1 disables regulator
// - Mode bit 0 normal, 1 low power
`timescale 1ns/100ps
`include "vbrc_map.svh"
module vbrc_top
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic bus_power_pin,
    output logic regulator_off,
    output logic regulator_low_power,
    output logic bus_power_irq,
    output logic bus_power_reset_req,
    output logic event_irq
);
    import vbrc_pkg::*;

    // Control, reset source and interrupt enable register fields
    logic regulator_off_bit_q;
    logic regulator_low_power_select_q;
    logic bus_power_polarity_select_q;
    logic irq_enable_q;
    logic reset_source_q;
    vbrc_ev_t ev_en_q;
    // Synchronised bus power level
    logic bus_level;
    logic match;
    logic match_prev_q;
    vbrc_ev_t ev_set;
    vbrc_ev_t ev_clr;
    vbrc_ev_t ev_stat;
    // Captured data phase
    vbrc_phase_t phase_q;
    logic wr_q;
    logic [31:0] addr_q;
    logic take;

    // Register fields sit in bit positions given by the map, except irq enable at bit 0
    function automatic logic [31:0] ctrl_word();
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`VBRC_BIT_OFF] = regulator_off_bit_q;
        w[`VBRC_BIT_STAT] = bus_level;
        w[`VBRC_BIT_POL] = bus_power_polarity_select_q;
        w[`VBRC_BIT_LP] = regulator_low_power_select_q;
        w[0] = irq_enable_q;
        return w;
    endfunction

    // Pin passes four flops (three stages and the filter) before anything here looks at it
    vbrc_sync u_sync
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin_in(bus_power_pin),
        .level_q(bus_level)
    );

    // Level match against chosen polarity; pure combinational so it tracks live
    assign match = (bus_level == bus_power_polarity_select_q);

    assign bus_power_irq = irq_enable_q & match;
    assign bus_power_reset_req = reset_source_q & match;
    assign regulator_off = regulator_off_bit_q;
    assign regulator_low_power = regulator_low_power_select_q;

    // Edge history of the match, used only for sticky events
    always_ff @(posedge hclk or negedge hresetn)
    begin
        // Polarity 0 and a low level match in reset, so history starts high: no false event
        if (!hresetn)
            match_prev_q <= 1'b1;
        else
            match_prev_q <= match;
    end

    assign ev_set[`VBRC_EV_MATCH_RISE] = match & ~match_prev_q;
    assign ev_set[`VBRC_EV_MATCH_FALL] = ~match & match_prev_q;

    // Address phase is taken when selected, active and bus ready
    assign take = hsel & hready & htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Write-one-to-clear strobe, one cycle in the data phase
    assign ev_clr = (phase_q == VBRC_DATA && wr_q && addr_q == `VBRC_OFF_ICLR)
        ? hwdata[1:0] : 2'b00;

    vbrc_evt u_evt
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .ev_set(ev_set),
        .ev_clr(ev_clr),
        .ev_en(ev_en_q),
        .ev_stat_q(ev_stat),
        .ev_irq(event_irq)
    );

    // Bus phase tracker
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            phase_q <= VBRC_ADDR;
            wr_q <= 1'b0;
            addr_q <= 32'h0000_0000;
        end
        else if (take)
        begin
            phase_q <= VBRC_DATA;
            wr_q <= hwrite;
            addr_q <= {haddr[31:2], 2'b00};
        end
        else
        begin
            phase_q <= VBRC_ADDR;
            wr_q <= 1'b0;
        end
    end

    // Register writes; reserved and read-only bits ignored
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            regulator_off_bit_q <= 1'(`VBRC_CTRL_RST >> `VBRC_BIT_OFF);
            regulator_low_power_select_q <= 1'b0;
            bus_power_polarity_select_q <= 1'b0;
            irq_enable_q <= 1'b0;
            reset_source_q <= 1'b0;
            ev_en_q <= 2'b00;
        end
        else if (phase_q == VBRC_DATA && wr_q)
        begin
            unique case (addr_q)
                `VBRC_OFF_CTRL:
                begin
                    regulator_off_bit_q <= hwdata[`VBRC_BIT_OFF];
                    regulator_low_power_select_q <= hwdata[`VBRC_BIT_LP];
                    bus_power_polarity_select_q <= hwdata[`VBRC_BIT_POL];
                    irq_enable_q <= hwdata[0];
                end
                `VBRC_OFF_RSTSRC:
                    reset_source_q <= hwdata[0];
                `VBRC_OFF_IEN:
                    ev_en_q <= hwdata[1:0];
                default:
                    ; // Unmapped or write-only targets store nothing
            endcase
        end
    end

    // Read data registered at the address phase, so it stands in the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (take && !hwrite)
        begin
            unique case ({haddr[31:2], 2'b00})
                `VBRC_OFF_CTRL: hrdata <= ctrl_word();
                `VBRC_OFF_RSTSRC: hrdata <= {31'h0, reset_source_q};
                `VBRC_OFF_ISTAT: hrdata <= {30'h0, ev_stat};
                `VBRC_OFF_IEN: hrdata <= {30'h0, ev_en_q};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Checks
    property p_irq_level;
        @(posedge hclk) disable iff (!hresetn)
        (irq_enable_q && bus_level == bus_power_polarity_select_q) |-> bus_power_irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq not raised on match");

    property p_irq_drop;
        @(posedge hclk) disable iff (!hresetn)
        $changed(bus_level) && !match |-> !bus_power_irq;
    endproperty
    a_irq_drop: assert property (p_irq_drop) else $error("irq held after mismatch");

    property p_no_latch;
        @(posedge hclk) disable iff (!hresetn)
        bus_power_irq |-> match;
    endproperty
    a_no_latch: assert property (p_no_latch) else $error("irq latched");

    property p_rst;
        @(posedge hclk) disable iff (!hresetn)
        bus_power_reset_req == (reset_source_q && match);
    endproperty
    a_rst: assert property (p_rst) else $error("reset request wrong");

    property p_pol0;
        @(posedge hclk) disable iff (!hresetn)
        (irq_enable_q && !bus_power_polarity_select_q && !bus_level) |-> bus_power_irq;
    endproperty
    a_pol0: assert property (p_pol0) else $error("polarity 0 not active low");

    property p_sync;
        @(posedge hclk) disable iff (!hresetn)
        $changed(bus_level) |-> $past(bus_power_pin, 3) == bus_level;
    endproperty
    a_sync: assert property (p_sync) else $error("sync path wrong");

    property p_stat;
        @(posedge hclk) disable iff (!hresetn)
        (take && !hwrite && {haddr[31:2], 2'b00} == `VBRC_OFF_CTRL)
            |=> hrdata[`VBRC_BIT_STAT] == $past(bus_level);
    endproperty
    a_stat: assert property (p_stat) else $error("status bit wrong");

    property p_off;
        @(posedge hclk) disable iff (!hresetn)
        (phase_q == VBRC_DATA && wr_q && addr_q == `VBRC_OFF_CTRL)
            |=> regulator_off == $past(hwdata[`VBRC_BIT_OFF])
            && regulator_low_power == $past(hwdata[`VBRC_BIT_LP]);
    endproperty
    a_off: assert property (p_off) else $error("control write lost");

    // Regulator controls move only on a write to the control word
    property p_off_hold;
        @(posedge hclk) disable iff (!hresetn)
        !(phase_q == VBRC_DATA && wr_q && addr_q == `VBRC_OFF_CTRL)
            |=> $stable(regulator_off) && $stable(regulator_low_power);
    endproperty
    a_off_hold: assert property (p_off_hold) else $error("control moved without write");

    // Reset request falls with the match, never held over
    property p_rst_drop;
        @(posedge hclk) disable iff (!hresetn)
        !match |-> !bus_power_reset_req;
    endproperty
    a_rst_drop: assert property (p_rst_drop) else $error("reset request held");

    // Polarity 1 makes a high bus power level the active one
    property p_pol1;
        @(posedge hclk) disable iff (!hresetn)
        (irq_enable_q && bus_power_polarity_select_q && bus_level) |-> bus_power_irq;
    endproperty
    a_pol1: assert property (p_pol1) else $error("polarity 1 not active high");

    // A disabled interrupt stays quiet whatever the level does
    property p_irq_off;
        @(posedge hclk) disable iff (!hresetn)
        !irq_enable_q |-> !bus_power_irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq raised while disabled");

    // An event always lands, even when software clears in the same cycle
    property p_set_wins;
        @(posedge hclk) disable iff (!hresetn)
        ev_set != 2'b00
            |=> (ev_stat & $past(ev_set)) == $past(ev_set);
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost to clear");

    // A clear with no event in that cycle empties the bits it names
    property p_clr;
        @(posedge hclk) disable iff (!hresetn)
        (ev_clr != 2'b00 && ev_set == 2'b00)
            |=> (ev_stat & $past(ev_clr)) == 2'b00;
    endproperty
    a_clr: assert property (p_clr) else $error("event clear ignored");

    // Read data moves only when a read is taken, so it stands through the data phase
    property p_rdata_hold;
        @(posedge hclk) disable iff (!hresetn)
        !(take && !hwrite) |=> $stable(hrdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

    // Main scenarios worth seeing in coverage
    c_irq: cover property (@(posedge hclk) disable iff (!hresetn) $rose(bus_power_irq));
    c_rst: cover property (@(posedge hclk) disable iff (!hresetn) $rose(bus_power_reset_req));
    c_ev: cover property (@(posedge hclk) disable iff (!hresetn) $rose(event_irq));
    c_drop: cover property (@(posedge hclk) disable iff (!hresetn) $fell(bus_power_irq));
    c_lp: cover property (@(posedge hclk) disable iff (!hresetn) $rose(regulator_low_power));
endmodule

// >>> vbrc_map.svh
// Register offsets, field positions, reset values and event bit indices
`ifndef VBRC_MAP_SVH
`define VBRC_MAP_SVH
`define VBRC_OFF_CTRL 32'h0000_0000
`define VBRC_OFF_RSTSRC 32'h0000_0004
`define VBRC_OFF_ISTAT 32'h0000_0008
`define VBRC_OFF_IEN 32'h0000_000c
`define VBRC_OFF_ICLR 32'h0000_0010
`define VBRC_BIT_OFF 7
`define VBRC_BIT_STAT 6
`define VBRC_BIT_POL 5
`define VBRC_BIT_LP 4
`define VBRC_CTRL_RST 8'h00
`define VBRC_EV_MATCH_RISE 0
`define VBRC_EV_MATCH_FALL 1
`define VBRC_NEV 2
`endif

// >>> vbrc_pkg.sv
// Types shared by the regulator control block
package vbrc_pkg;
    typedef logic [7:0] vbrc_ctrl_t;
    typedef logic [1:0] vbrc_ev_t;
    typedef enum logic [1:0] {
        VBRC_ADDR = 2'b01,
        VBRC_DATA = 2'b10
    } vbrc_phase_t;
endpackage

// >>> vbrc_sync.sv
// Three-stage synchroniser with agreement filter for the bus power pin
`timescale 1ns/100ps
module vbrc_sync
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic pin_in,
    output logic level_q
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // Shift chain; the first stage feeds only the second
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end
        else
        begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Accept a change only once stages two and three agree
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            level_q <= 1'b0;
        else if (s2_q == s3_q)
            level_q <= s3_q;
    end
endmodule

// >>> vbrc_evt.sv
// Sticky event status bits with enable and write-one-to-clear
`timescale 1ns/100ps
`include "vbrc_map.svh"
module vbrc_evt
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire vbrc_pkg::vbrc_ev_t ev_set,
    input wire vbrc_pkg::vbrc_ev_t ev_clr,
    input wire vbrc_pkg::vbrc_ev_t ev_en,
    output vbrc_pkg::vbrc_ev_t ev_stat_q,
    output logic ev_irq
);
    import vbrc_pkg::*;

    // One sticky bit per event; a set in the clear cycle wins
    genvar gi;
    generate
        for (gi = 0; gi < `VBRC_NEV; gi++)
        begin : g_bit
            always_ff @(posedge hclk or negedge hresetn)
            begin
                if (!hresetn)
                    ev_stat_q[gi] <= 1'b0;
                else if (ev_set[gi])
                    ev_stat_q[gi] <= 1'b1;
                else if (ev_clr[gi])
                    ev_stat_q[gi] <= 1'b0;
            end
        end
    endgenerate

    // Level output while any enabled bit stands
    assign ev_irq = |(ev_stat_q & ev_en);
endmodule

// >>> vbrc_vbus_host.sv
// Behavioural USB host or hub that supplies bus power to the device
`timescale 1ns/100ps
module vbrc_vbus_host
(
    output logic bus_power_pin
);
    // Detached at power-up, so bus power starts absent
    initial
    begin
        bus_power_pin = 1'b0;
    end

    // Attach or detach; the level lands on the detection pin, not the regulator input
    task automatic drive(input logic lvl);
        bus_power_pin = lvl;
    endtask
endmodule

// >>> testbench.sv
// Self-checking bench for the regulator control block
`timescale 1ns/100ps
`include "vbrc_map.svh"
module testbench;
    import vbrc_pkg::*;
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic bus_power_pin;
    logic regulator_off;
    logic regulator_low_power;
    logic bus_power_irq;
    logic bus_power_reset_req;
    logic event_irq;
    logic [31:0] rd; // Last read data
    int n_fail = 0;
    int samples_checked = 0;

    // Ready is looped back from the slave, as on a one-slave bus
    vbrc_top i_vbrc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .bus_power_pin(bus_power_pin),
        .regulator_off(regulator_off), .regulator_low_power(regulator_low_power),
        .bus_power_irq(bus_power_irq), .bus_power_reset_req(bus_power_reset_req),
        .event_irq(event_irq));
    vbrc_vbus_host i_vbrc_vbus_host (.bus_power_pin(bus_power_pin));

    // Free-running 50 MHz clock
    initial
    begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    // Prints counts and verdict, then stops
    task automatic test_done();
        $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Bounded wait for ready; a hang counts as a mismatch
    task automatic wait_rdy();
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1)
        begin
            n_fail++;
            test_done();
        end
    endtask

    // One single word transfer: address phase, then data phase
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        // Start on a rising edge so every change lands right after it
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
        hsel <= 1'b0;
        // Let this edge's register updates land before any check reads an output
        #1;
    endtask

    // Compare and count; the delay lets the edge's updates land first
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        #1;
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask

    task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // Change bus power, then allow the synchroniser to settle
    task automatic pin(input logic lvl);
        i_vbrc_vbus_host.drive(lvl);
        repeat (6) @(posedge hclk);
    endtask

    // Main sequence
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk(`VBRC_OFF_CTRL, 32'h0);
        chk1(regulator_off, 1'b0);
        chk1(regulator_low_power, 1'b0);
        chk1(bus_power_irq, 1'b0);
        chk1(hresp, 1'b0);
        $display("Test reset values done");
        // Reserved bits are written as ones but must read back zero
        xfer(1'b1, `VBRC_OFF_CTRL, 32'h8e);
        chk1(regulator_off, 1'b1);
        rchk(`VBRC_OFF_CTRL, 32'h80);
        xfer(1'b1, `VBRC_OFF_CTRL, 32'h10);
        chk1(regulator_off, 1'b0);
        chk1(regulator_low_power, 1'b1);
        rchk(`VBRC_OFF_CTRL, 32'h10);
        $display("Test regulator control done");
        // Every polarity against every level, irq and reset source on
        xfer(1'b1, `VBRC_OFF_RSTSRC, 32'h1);
        for (int p = 0; p < 2; p++)
        begin
            for (int l = 0; l < 2; l++)
            begin
                xfer(1'b1, `VBRC_OFF_CTRL, {26'h0, p[0], 4'h0, 1'b1});
                pin(l[0]);
                chk1(bus_power_irq, l[0] == p[0]);
                chk1(bus_power_reset_req, l[0] == p[0]);
                rchk(`VBRC_OFF_CTRL, {25'h0, l[0], p[0], 4'h0, 1'b1});
            end
        end
        // Match stands, but both enables now off
        xfer(1'b1, `VBRC_OFF_CTRL, 32'h20);
        xfer(1'b1, `VBRC_OFF_RSTSRC, 32'h0);
        chk1(bus_power_irq, 1'b0);
        chk1(bus_power_reset_req, 1'b0);
        $display("Test polarity and match done");
        // Sticky events: clear, read-only status, mask and unmask
        xfer(1'b1, `VBRC_OFF_IEN, 32'h3);
        xfer(1'b1, `VBRC_OFF_ICLR, 32'h3);
        xfer(1'b1, `VBRC_OFF_ISTAT, 32'h3);
        rchk(`VBRC_OFF_ISTAT, 32'h0);
        pin(1'b0);
        chk1(event_irq, 1'b1);
        rchk(`VBRC_OFF_ISTAT, 32'h2);
        xfer(1'b1, `VBRC_OFF_ICLR, 32'h2);
        rchk(`VBRC_OFF_ISTAT, 32'h0);
        chk1(event_irq, 1'b0);
        xfer(1'b1, `VBRC_OFF_IEN, 32'h0);
        pin(1'b1);
        chk1(event_irq, 1'b0);
        rchk(`VBRC_OFF_ISTAT, 32'h1);
        xfer(1'b1, `VBRC_OFF_IEN, 32'h1);
        chk1(event_irq, 1'b1);
        xfer(1'b1, `VBRC_OFF_ICLR, 32'h1);
        chk1(event_irq, 1'b0);
        rchk(`VBRC_OFF_ICLR, 32'h0);
        // Unmapped place: write ignored, reads zero
        xfer(1'b1, 32'h0000_0020, 32'hffff_ffff);
        rchk(32'h0000_0020, 32'h0);
        $display("Test events and map done");
        test_done();
    end
endmodule
